// ==== rtl/dgio_map.svh ====
// offsets, field positions, reset values and counts of the parallel i/o
`ifndef DGIO_MAP_SVH
`define DGIO_MAP_SVH
`define DGIO_OFF_PORT_A  2'h0
`define DGIO_OFF_PORT_B  2'h1
`define DGIO_OFF_PORT_C  2'h2
`define DGIO_OFF_DIR     2'h3
`define DGIO_GRP_BIT     2
`define DGIO_BLOCK_BIT   3
`define DGIO_DIR_FLAG    7
`define DGIO_DIR_A       4
`define DGIO_DIR_CU      3
`define DGIO_DIR_B       1
`define DGIO_DIR_CL      0
`define DGIO_DIR_RST     4'hf
`define DGIO_LATCH_RST   8'h00
`define DGIO_UNDEF_RD    8'hff
`define DGIO_IRQ_LINES   3'h6
`define DGIO_SRC_BIT     0
`define DGIO_GATE_BIT    4
`endif

// ==== rtl/dgio_pkg.sv ====
// types shared by the parallel i/o modules
package dgio_pkg;
    typedef enum logic [1:0] {
        dgio_irq_on        = 2'h0,
        dgio_irq_off       = 2'h1,
        dgio_irq_pin_gated = 2'h3
    } dgio_irq_mode_t;
    typedef enum logic {
        dgio_rise = 1'h0,
        dgio_fall = 1'h1
    } dgio_edge_t;
    typedef enum logic [1:0] {
        dgio_bus_idle = 2'h0,
        dgio_bus_rd   = 2'h1,
        dgio_bus_wr   = 2'h2
    } dgio_bus_st_t;
    typedef struct packed {
        logic [2:0][7:0] latch;
        logic            dir_a;
        logic            dir_cu;
        logic            dir_b;
        logic            dir_cl;
    } dgio_grp_state_t;
    typedef struct packed {
        dgio_bus_st_t bus_st;
        logic [7:0]   rd_data;
        logic         rd_oe_n;
        logic [1:0]   src_s1;
        logic [1:0]   src_s2;
        logic [1:0]   src_s3;
        logic [1:0]   gate_s1;
        logic [1:0]   gate_s2;
        logic [1:0]   ev;
        logic [2:0]   sync_fill;
        logic [5:0]   irq;
    } dgio_top_state_t;
endpackage

// ==== rtl/dgio_grp_if.sv ====
// register access path between the decoder and one port group
`timescale 1ns/1ps
`default_nettype none
interface dgio_grp_if;
    logic       wr;
    logic [1:0] off;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport dec (output wr, output off, output wdata, input rdata);
    modport grp (input wr, input off, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== rtl/dgio_grp.sv ====
// one 24-line group: three port latches, direction control, read mux
`timescale 1ns/1ps
`default_nettype none
`include "dgio_map.svh"
module dgio_grp
    import dgio_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            rstn,
    dgio_grp_if.grp              bus,
    input  wire logic [2:0][7:0] pin_in,
    output logic      [2:0][7:0] pin_out,
    output logic      [2:0][7:0] pin_oe_n
);
    dgio_grp_state_t st_q;
    dgio_grp_state_t st_d;
    logic [2:0][7:0] in_mask;
    logic [1:0]      rd_idx;

    // RQ2 per-port direction
    assign in_mask = {{4{st_q.dir_cu}}, {4{st_q.dir_cl}},
                      {8{st_q.dir_b}}, {8{st_q.dir_a}}};
    assign pin_out  = st_q.latch;
    assign pin_oe_n = in_mask;

    // RQ19 readback of outputs
    assign rd_idx    = (bus.off == `DGIO_OFF_DIR) ? 2'h0 : bus.off;
    assign bus.rdata = (pin_in[rd_idx] & in_mask[rd_idx])
                     | (st_q.latch[rd_idx] & ~in_mask[rd_idx]);

    // writes land in a latch or in the direction bits
    always_comb begin
        st_d = st_q;
        if (bus.wr) begin
            case (bus.off)
                `DGIO_OFF_DIR: begin
                    // RQ16 flagged direction word
                    if (bus.wdata[`DGIO_DIR_FLAG]) begin
                        st_d.dir_a  = bus.wdata[`DGIO_DIR_A];
                        st_d.dir_cu = bus.wdata[`DGIO_DIR_CU];
                        st_d.dir_b  = bus.wdata[`DGIO_DIR_B];
                        st_d.dir_cl = bus.wdata[`DGIO_DIR_CL];
                    end
                end
                // RQ12 outputs held latched
                default: st_d.latch[bus.off] = bus.wdata;
            endcase
        end
    end

    // RQ17 all ports input
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= {{3{`DGIO_LATCH_RST}}, `DGIO_DIR_RST};
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RQ12 latch takes write
    a_latch_write: assert property ( // RQ12
        @(posedge ref_clk) disable iff (!rstn)
        bus.wr && bus.off == `DGIO_OFF_PORT_A
        |=> pin_out[0] == $past(bus.wdata))
        else $error("port a latch missed a write");
    // RQ12 latch holds otherwise
    a_latch_hold: assert property ( // RQ12
        @(posedge ref_clk) disable iff (!rstn)
        !bus.wr |=> $stable(pin_out))
        else $error("latch changed without a write");
    // RQ16 direction word applied
    a_dir_write: assert property ( // RQ16
        @(posedge ref_clk) disable iff (!rstn)
        bus.wr && bus.off == `DGIO_OFF_DIR && bus.wdata[`DGIO_DIR_FLAG]
        |=> pin_oe_n[0] == {8{$past(bus.wdata[`DGIO_DIR_A])}})
        else $error("port a direction not taken");
    // RQ16 unflagged word ignored
    a_dir_ignored: assert property ( // RQ16
        @(posedge ref_clk) disable iff (!rstn)
        bus.wr && bus.off == `DGIO_OFF_DIR && !bus.wdata[`DGIO_DIR_FLAG]
        |=> $stable(pin_oe_n))
        else $error("direction changed on unflagged word");
    // RQ19 output reads latch
    a_out_readback: assert property ( // RQ19
        @(posedge ref_clk) disable iff (!rstn)
        pin_oe_n[1] == 8'h00 && bus.off == `DGIO_OFF_PORT_B
        |-> bus.rdata == pin_out[1])
        else $error("output port did not read back its latch");
endmodule
`default_nettype wire

// ==== rtl/dgio_top.sv ====
// dual group parallel i/o: host decode, port groups, edge interrupts
//
// How it works
// RQ1 - forty-eight lines in two identical groups
// RQ2 - three byte ports, each input or output
// RQ3 - answer only eight addresses from base
// RQ4 - switches match address bits nine to four
// RQ5 - port c bit zero triggers, edge selectable
// RQ6 - rising edge selected: low-to-high fires
// RQ7 - falling edge selected: high-to-low fires
// RQ8 - interrupts on, off or pin gated
// RQ9 - gated mode: port c bit four enables
// RQ10 - each group routed to one irq line
// RQ11 - no handshake; write updates, read answers
// RQ12 - outputs latched, inputs read live
// RQ13 - ports at offsets zero-two and four-six
// RQ14 - group zero direction at three, write-only
// RQ15 - group one direction at seven, same layout
// RQ16 - direction word: flag bit seven, port bits
// RQ17 - after reset every port is input
// RQ18 - source synchronised, one-cycle interrupt pulses
// RQ19 - output ports read back their latch
`timescale 1ns/1ps
`default_nettype none
`include "dgio_map.svh"
module dgio_top
    import dgio_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic [9:0]           io_addr,
    input  wire logic                 io_rd_n,
    input  wire logic                 io_wr_n,
    input  wire logic [7:0]           io_data_in,
    output logic      [7:0]           io_data_out,
    output logic                      io_data_oe_n,
    input  wire logic [5:0]           base_address_switch,
    input  wire dgio_edge_t           edge_select_grp0,
    input  wire dgio_edge_t           edge_select_grp1,
    input  wire dgio_irq_mode_t       irq_mode,
    input  wire logic [2:0]           irq_route_grp0,
    input  wire logic [2:0]           irq_route_grp1,
    input  wire logic [1:0][2:0][7:0] port_in,
    output logic      [1:0][2:0][7:0] port_out,
    output logic      [1:0][2:0][7:0] port_oe_n,
    output logic      [5:0]           irq_lines
);
    localparam dgio_top_state_t ST_RST = '{
        bus_st  : dgio_bus_idle,
        rd_oe_n : 1'b1,
        default : '0
    };

    dgio_top_state_t   st_q;
    dgio_top_state_t   st_d;
    logic              hit;
    logic              wr_take;
    logic              rd_go;
    logic [7:0]        rd_word;
    logic [1:0][7:0]   grp_rd;
    logic [1:0]        src_pin;
    logic [1:0]        gate_pin;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // switch on matches a zero address bit; switch one faces bit nine
    function automatic logic addr_hit(
        input logic [9:0] a,
        input logic [5:0] sw
    );
        logic [5:0] want;
        for (int i = 0; i < 6; i++) begin
            want[5-i] = ~sw[i];
        end
        addr_hit = (a[9:4] == want) && !a[`DGIO_BLOCK_BIT];
    endfunction

    // edge of the synchronised source against its last sample
    function automatic logic edge_seen(
        input logic       now,
        input logic       was,
        input dgio_edge_t e
    );
        if (e == dgio_rise) begin
            edge_seen = now && !was;
        end else begin
            edge_seen = !now && was;
        end
    endfunction

    // global mode, with a per-group gate pin in gated mode
    function automatic logic irq_allowed(
        input dgio_irq_mode_t m,
        input logic           gate
    );
        case (m)
            dgio_irq_on:        irq_allowed = 1'b1;
            dgio_irq_pin_gated: irq_allowed = gate;
            default:            irq_allowed = 1'b0;
        endcase
    endfunction

    // route select 0..5 means irq 2..7; larger codes go nowhere
    function automatic logic [5:0] route_onehot(
        input logic       ev,
        input logic [2:0] sel
    );
        route_onehot = 6'h00;
        if (ev && sel < `DGIO_IRQ_LINES) begin
            route_onehot[sel] = 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // address decode and bus strobes

    // RQ4 base switch compare
    // RQ3 eight locations only
    assign hit = addr_hit(io_addr, base_address_switch);

    // RQ11 one write per strobe
    assign wr_take = (st_q.bus_st == dgio_bus_idle) && !io_wr_n && hit;

    // a read overlapping a write strobe is dropped, never half served
    assign rd_go = !io_rd_n && io_wr_n && hit
                && (st_q.bus_st != dgio_bus_wr);

    // RQ14 direction reads undefined
    // RQ15 same for group one
    assign rd_word = (io_addr[1:0] == `DGIO_OFF_DIR) ? `DGIO_UNDEF_RD
                   : grp_rd[io_addr[`DGIO_GRP_BIT]];

    ////////////////////////////////////////////////////////////////////////
    // the two groups

    // RQ1 two identical groups
    // RQ13 group picked by bit two
    for (genvar g = 0; g < 2; g++) begin : gen_grp
        dgio_grp_if gif ();

        assign gif.wr    = wr_take && (io_addr[`DGIO_GRP_BIT] == 1'(g));
        assign gif.off   = io_addr[1:0];
        assign gif.wdata = io_data_in;
        assign grp_rd[g] = gif.rdata;

        // RQ5 port c bit zero
        assign src_pin[g]  = port_in[g][2][`DGIO_SRC_BIT];
        // RQ9 port c bit four
        assign gate_pin[g] = port_in[g][2][`DGIO_GATE_BIT];

        dgio_grp i_dgio_grp (
            .ref_clk  (ref_clk),
            .rstn     (rstn),
            .bus      (gif),
            .pin_in   (port_in[g]),
            .pin_out  (port_out[g]),
            .pin_oe_n (port_oe_n[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_d = st_q;

        // RQ18 two-stage synchroniser
        st_d.src_s1  = src_pin;
        st_d.src_s2  = st_q.src_s1;
        st_d.src_s3  = st_q.src_s2;
        st_d.gate_s1 = gate_pin;
        st_d.gate_s2 = st_q.gate_s1;
        // edge stage holds a real sample only from the third clock on;
        // until then a pin resting high would pass for a rise
        st_d.sync_fill = {st_q.sync_fill[1:0], 1'b1};

        // RQ6 rising edge fires
        // RQ7 falling edge fires
        // RQ8 mode shared by groups
        st_d.ev[0] = edge_seen(st_q.src_s2[0], st_q.src_s3[0],
                               edge_select_grp0)
                  && irq_allowed(irq_mode, st_q.gate_s2[0])
                  && st_q.sync_fill[2];
        st_d.ev[1] = edge_seen(st_q.src_s2[1], st_q.src_s3[1],
                               edge_select_grp1)
                  && irq_allowed(irq_mode, st_q.gate_s2[1])
                  && st_q.sync_fill[2];

        // RQ10 route to irq line
        st_d.irq = route_onehot(st_q.ev[0], irq_route_grp0)
                 | route_onehot(st_q.ev[1], irq_route_grp1);

        // bus cycle tracking; a held strobe must not repeat its write
        case (st_q.bus_st)
            dgio_bus_idle: begin
                if (wr_take) begin
                    st_d.bus_st = dgio_bus_wr;
                end else if (rd_go) begin
                    st_d.bus_st = dgio_bus_rd;
                end
            end
            dgio_bus_rd: begin
                if (!rd_go) begin
                    st_d.bus_st = dgio_bus_idle;
                end
            end
            dgio_bus_wr: begin
                if (io_wr_n) begin
                    st_d.bus_st = dgio_bus_idle;
                end
            end
            default: begin
                st_d.bus_st = dgio_bus_idle;
            end
        endcase

        // RQ11 read answers directly
        // RQ12 live pins each cycle
        st_d.rd_oe_n = !rd_go;
        if (rd_go) begin
            st_d.rd_data = rd_word;
        end
    end

    // one register bank for the whole decoder
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state flops
    assign io_data_out  = st_q.rd_data;
    assign io_data_oe_n = st_q.rd_oe_n;
    assign irq_lines    = st_q.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_rd_req;
        !io_rd_n && io_wr_n && hit && st_q.bus_st != dgio_bus_wr;
    endsequence

    sequence s_src0_rise;
        st_q.sync_fill[2] && !st_q.src_s3[0] && st_q.src_s2[0];
    endsequence

    sequence s_src1_fall;
        st_q.sync_fill[2] && st_q.src_s3[1] && !st_q.src_s2[1];
    endsequence

    // RQ11 read answered next cycle
    a_read_answer: assert property ( // RQ11
        @(posedge ref_clk) disable iff (!rstn)
        s_rd_req |=> !io_data_oe_n && io_data_out == $past(rd_word))
        else $error("read not answered with the addressed port");

    // RQ3 foreign address silent
    a_foreign_quiet: assert property ( // RQ3
        @(posedge ref_clk) disable iff (!rstn)
        !hit |=> io_data_oe_n)
        else $error("data bus driven for a foreign address");

    // RQ11 single write per strobe
    a_write_once: assert property ( // RQ11
        @(posedge ref_clk) disable iff (!rstn)
        wr_take |=> !wr_take)
        else $error("one strobe gave two writes");

    // RQ6 rising edge raises irq
    a_rise_irq: assert property ( // RQ6
        @(posedge ref_clk) disable iff (!rstn)
        s_src0_rise and (edge_select_grp0 == dgio_rise
            && irq_mode == dgio_irq_on
            && irq_route_grp0 < `DGIO_IRQ_LINES)
        |=> st_q.ev[0] ##1 irq_lines[$past(irq_route_grp0, 2)])
        else $error("rising edge gave no interrupt");

    // RQ7 falling edge raises irq
    a_fall_irq: assert property ( // RQ7
        @(posedge ref_clk) disable iff (!rstn)
        s_src1_fall and (edge_select_grp1 == dgio_fall
            && irq_mode == dgio_irq_on)
        |=> st_q.ev[1])
        else $error("falling edge gave no interrupt");

    // RQ5 wrong edge ignored
    a_wrong_edge: assert property ( // RQ5
        @(posedge ref_clk) disable iff (!rstn)
        s_src0_rise and (edge_select_grp0 == dgio_fall)
        |=> !st_q.ev[0])
        else $error("interrupt on the unselected edge");

    // RQ8 off mode silent
    a_irq_off: assert property ( // RQ8
        @(posedge ref_clk) disable iff (!rstn)
        irq_mode == dgio_irq_off |=> ##1 irq_lines == 6'h00)
        else $error("interrupt while disabled");

    // RQ9 gate low blocks
    a_gate_low: assert property ( // RQ9
        @(posedge ref_clk) disable iff (!rstn)
        irq_mode == dgio_irq_pin_gated && !st_q.gate_s2[0]
        |=> !st_q.ev[0])
        else $error("gated interrupt fired with gate low");

    // RQ18 pulse lasts one cycle
    a_single_pulse: assert property ( // RQ18
        @(posedge ref_clk) disable iff (!rstn)
        st_q.ev[0] |=> !st_q.ev[0])
        else $error("interrupt event longer than one cycle");

    // RQ10 event reaches its line
    a_irq_route: assert property ( // RQ10
        @(posedge ref_clk) disable iff (!rstn)
        st_q.ev[1] && irq_route_grp1 < `DGIO_IRQ_LINES
        |=> irq_lines[$past(irq_route_grp1)])
        else $error("group one event missed its irq line");

    // RQ18 quiet out of reset
    a_reset_quiet: assert property ( // RQ18
        @(posedge ref_clk) disable iff (!rstn)
        !st_q.sync_fill[2] |=> st_q.ev == 2'b00)
        else $error("interrupt event before the synchroniser filled");

    // RQ14 direction read undefined
    a_dir_read: assert property ( // RQ14
        @(posedge ref_clk) disable iff (!rstn)
        s_rd_req and (io_addr[1:0] == `DGIO_OFF_DIR)
        |=> io_data_out == `DGIO_UNDEF_RD)
        else $error("direction register read gave a port value");

    // RQ11 bus let go after read
    a_read_release: assert property ( // RQ11
        @(posedge ref_clk) disable iff (!rstn)
        io_rd_n |=> io_data_oe_n)
        else $error("data bus still driven after the read strobe");

    // RQ13 write lands in group one
    a_grp1_write: assert property ( // RQ13
        @(posedge ref_clk) disable iff (!rstn)
        wr_take && io_addr[`DGIO_GRP_BIT]
            && io_addr[1:0] == `DGIO_OFF_PORT_C
        |=> port_out[1][2] == $past(io_data_in))
        else $error("group one port c missed a write");
endmodule
`default_nettype wire

// ==== dv/dgio_host_model.sv ====
// host side of the i/o bus: byte reads and writes on the two strobes
`timescale 1ns/1ps
`default_nettype none
module dgio_host_model (
    input  wire logic       ref_clk,
    output logic      [9:0] io_addr,
    output logic            io_rd_n,
    output logic            io_wr_n,
    output logic      [7:0] io_data_in,
    input  wire logic [7:0] io_data_out,
    input  wire logic       io_data_oe_n
);
    // idle bus: both strobes high from time zero
    initial begin
        io_addr    = 10'h000;
        io_rd_n    = 1'b1;
        io_wr_n    = 1'b1;
        io_data_in = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // released lines show the inverse of their last value, so a stale
    // address or byte can never pass for a fresh one
    task automatic release_bus();
        io_addr    = ~io_addr;
        io_data_in = ~io_data_in;
    endtask

    // strobe, no handshake
    // strobe low over one sampled edge, then high for at least one more
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        io_addr    = a;
        io_data_in = d;
        io_wr_n    = 1'b0;
        @(negedge ref_clk);
        io_wr_n = 1'b1;
        release_bus();
        @(negedge ref_clk);
    endtask

    // answer next cycle
    // data is taken half a cycle after the taking edge, then released
    task automatic rd(input logic [9:0] a, output logic [7:0] d,
                      output logic drv);
        @(negedge ref_clk);
        io_addr = a;
        io_rd_n = 1'b0;
        @(negedge ref_clk);
        d       = io_data_out;
        drv     = ~io_data_oe_n;
        io_rd_n = 1'b1;
        release_bus();
        @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_dgio_top.sv ====
// self-checking bench for the dual group parallel i/o
`timescale 1ns/1ps
`default_nettype none
`include "dgio_map.svh"
module tb_dgio_top
    import dgio_pkg::*;
;
    logic                 ref_clk;
    logic                 rstn;
    logic [9:0]           io_addr;
    logic                 io_rd_n;
    logic                 io_wr_n;
    logic [7:0]           io_data_in;
    logic [7:0]           io_data_out;
    logic                 io_data_oe_n;
    logic [5:0]           base_address_switch;
    dgio_edge_t           edge_select_grp0;
    dgio_edge_t           edge_select_grp1;
    dgio_irq_mode_t       irq_mode;
    logic [2:0]           irq_route_grp0;
    logic [2:0]           irq_route_grp1;
    logic [1:0][2:0][7:0] port_in;
    logic [1:0][2:0][7:0] port_out;
    logic [1:0][2:0][7:0] port_oe_n;
    logic [5:0]           irq_lines;
    logic [1:0][2:0][7:0] ext_pins;
    logic [47:0]          exp_oe;
    logic [9:0]           base;
    logic [7:0]           v;
    logic [7:0]           dirw [6];
    int                   fails = 0;
    int                   checks_done = 0;
    int                   cycles = 0;

    // pin level: our latch where driven, the outside world elsewhere
    assign port_in = (port_oe_n & ext_pins) | (~port_oe_n & port_out);

    dgio_top i_dgio_top (.ref_clk(ref_clk), .rstn(rstn), .io_addr(io_addr),
        .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_data_in(io_data_in),
        .io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n),
        .base_address_switch(base_address_switch),
        .edge_select_grp0(edge_select_grp0),
        .edge_select_grp1(edge_select_grp1), .irq_mode(irq_mode),
        .irq_route_grp0(irq_route_grp0), .irq_route_grp1(irq_route_grp1),
        .port_in(port_in), .port_out(port_out), .port_oe_n(port_oe_n),
        .irq_lines(irq_lines));

    dgio_host_model i_dgio_host_model (.ref_clk(ref_clk), .io_addr(io_addr),
        .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_data_in(io_data_in),
        .io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n));

    ////////////////////////////////////////////////////////////////////////
    // 250 mhz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // switch i+1 watches address bit 9-i; on (1) matches a zero bit
    function automatic logic [5:0] sw_for(input logic [9:0] a);
        logic [5:0] s;
        for (int i = 0; i < 6; i++) begin
            s[i] = ~a[9 - i];
        end
        return s;
    endfunction

    // direction word to pin enables {c, b, a}; a one bit means input
    function automatic logic [23:0] dir_oe(input logic [7:0] w);
        return {{4{w[3]}}, {4{w[0]}}, {8{w[1]}}, {8{w[4]}}};
    endfunction

    // read, compare, then see the data bus let go again
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp,
                          input logic drv_exp);
        logic [7:0] d;
        logic       drv;
        i_dgio_host_model.rd(a, d, drv);
        chk(drv, drv_exp);
        if (drv_exp) begin
            chk(d, exp);
        end
        @(negedge ref_clk);
        chk(io_data_oe_n, 1'b1);
    endtask

    // one edge on port c bit 0, then the opposite edge, counting pulses
    task automatic irq_case(input int g, input dgio_edge_t e,
                            input dgio_irq_mode_t m, input logic gate,
                            input logic [2:0] route, input logic fire);
        logic [5:0] seen;
        int         hits;
        irq_mode         = m;
        edge_select_grp0 = e;
        edge_select_grp1 = e;
        irq_route_grp0   = (g == 1) ? 3'h7 : route;
        irq_route_grp1   = (g == 1) ? route : 3'h7;
        ext_pins[g][2][0] = (e == dgio_fall);
        ext_pins[g][2][4] = gate;
        repeat (8) @(negedge ref_clk);
        for (int t = 0; t < 2; t++) begin
            ext_pins[g][2][0] = ~ext_pins[g][2][0];
            seen = 6'h00;
            hits = 0;
            repeat (8) begin
                @(negedge ref_clk);
                seen = seen | irq_lines;
                hits += (irq_lines !== 6'h00);
            end
            chk(seen, (fire && t == 0) ? 6'h01 << route : 6'h00);
            chk(hits, (fire && t == 0) ? 1 : 0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        dirw = '{8'h90, 8'h88, 8'h82, 8'h81, 8'h1b, 8'h80};
        rstn = 1'b0;
        base = 10'h300;
        base_address_switch = sw_for(base);
        edge_select_grp0 = dgio_rise;
        edge_select_grp1 = dgio_rise;
        // group 0 source rests high with rise selected and a live route:
        // any edge seen out of reset would show on line 0
        irq_mode = dgio_irq_on;
        irq_route_grp0 = 3'h0;
        irq_route_grp1 = 3'h7;
        ext_pins = 48'h665544332211;
        repeat (12) @(negedge ref_clk);
        rstn = 1'b1;
        exp_oe = {48{1'b1}};
        chk(port_oe_n, exp_oe);
        chk(irq_lines, 6'h00);
        repeat (6) begin
            @(negedge ref_clk);
            chk(irq_lines, 6'h00);
        end
        irq_mode = dgio_irq_off;
        irq_route_grp0 = 3'h7;
        for (int b = 0; b < 2; b++) begin
            base = (b == 1) ? 10'h210 : 10'h300;
            base_address_switch = sw_for(base);
            rd_chk(base, ext_pins[0][0], 1'b1);
            rd_chk(base + 10'h008, 8'h00, 1'b0);
            rd_chk(base ^ 10'h200, 8'h00, 1'b0);
            rd_chk(base ^ 10'h010, 8'h00, 1'b0);
        end
        for (int a = 0; a < 8; a++) begin
            v = (a % 4 == 3) ? `DGIO_UNDEF_RD : ext_pins[a / 4][a % 4];
            rd_chk(base + 10'(a), v, 1'b1);
        end
        ext_pins[1][1] = 8'h9e;
        rd_chk(base + 10'h005, 8'h9e, 1'b1);
        for (int g = 0; g < 2; g++) begin
            for (int k = 0; k < 6; k++) begin
                i_dgio_host_model.wr(base + 10'(g * 4 + 3), dirw[k]);
                if (dirw[k][7]) begin
                    exp_oe[g * 24 +: 24] = dir_oe(dirw[k]);
                end
                chk(port_oe_n, exp_oe);
            end
            for (int p = 0; p < 3; p++) begin
                v = 8'h3c + 8'(33 * (3 * g + p));
                i_dgio_host_model.wr(base + 10'(g * 4 + p), v);
                chk(port_out[g][p], v);
                ext_pins[g][p] = ~v;
                rd_chk(base + 10'(g * 4 + p), v, 1'b1);
            end
            i_dgio_host_model.wr(base + 10'(g * 4 + 3), 8'h9b);
            exp_oe[g * 24 +: 24] = 24'hffffff;
            chk(port_oe_n, exp_oe);
            for (int p = 0; p < 3; p++) begin
                v = 8'h3c + 8'(33 * (3 * g + p));
                chk(port_out[g][p], v);
                rd_chk(base + 10'(g * 4 + p), ~v, 1'b1);
            end
        end
        irq_case(0, dgio_rise, dgio_irq_on, 1'b0, 3'h0, 1'b1);
        irq_case(1, dgio_fall, dgio_irq_on, 1'b0, 3'h5, 1'b1);
        irq_case(0, dgio_fall, dgio_irq_off, 1'b1, 3'h2, 1'b0);
        irq_case(1, dgio_rise, dgio_irq_pin_gated, 1'b1, 3'h3, 1'b1);
        irq_case(0, dgio_rise, dgio_irq_pin_gated, 1'b0, 3'h1, 1'b0);
        irq_case(1, dgio_rise, dgio_irq_on, 1'b1, 3'h4, 1'b1);
        irq_case(0, dgio_fall, dgio_irq_on, 1'b1, 3'h6, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
